// ---- logic/pmcc_top.sv ----
// Implementation choices: the register addresses and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
`include "pmcc_params.svh"

module pmcc_top
  import pmcc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic wake_up,
  output logic slow_osc_en,
  output logic fast_osc_en,
  output logic timer_clock_slow_select,
  output logic core_clock_slow_select,
  output logic [4:0] window_tap,
  output logic core_clk_run,
  output logic fast_osc_pin_run,
  output logic idle_timer_run,
  output logic internal_reset,
  output logic halt_active,
  output logic idle_active
);

  // Bus request qualifiers
  logic bus_req; // New request this cycle
  logic wr_mode; // Write to mode register
  logic wr_portg; // Write to port G control
  logic wr_option; // Write to option register

  // Stored registers
  logic [7:0] power_mode_register_q; // Clock and window control
  logic [7:0] option_q; // HALT availability
  logic ack_q; // Wishbone acknowledge
  logic [31:0] rd_q; // Registered read data

  // Instruction cycle divider
  logic [2:0] div_q; // Clock phase within one cycle
  logic tc_tick; // End of an instruction cycle
  logic tc_mid; // Middle of an instruction cycle
  logic [3:0] idle_timer_lo_q; // Low nibble of the timer; stops in HALT

  // Internal reset counter
  logic [7:0] irst_cnt_q; // Remaining instruction cycles
  logic irst_q; // Internal reset in progress

  // Power save state
  pmcc_ps_t ps_q; // Run, halt pending, halt or idle

  // Legality check outputs
  logic legal; // Upper nibble is one of five patterns
  logic force_low; // Invalid select pair seen
  pmcc_mode_t mode; // Decoded operating mode

  // Accept a request once; ack drops the cycle after it rose
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr_mode = bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `PMCC_ADR_MODE);
  assign wr_portg = bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `PMCC_ADR_PORTG);
  assign wr_option = bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `PMCC_ADR_OPTION);

  // Legality is judged on stored contents, one cycle after a write
  pmcc_legal_check u_legal (
    .upper(power_mode_register_q[7:4]),
    .legal(legal),
    .force_low(force_low),
    .mode(mode)
  );

  // Acknowledge one cycle after every request, mapped or not
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req;
    end
  end

  // Read mux, registered; unmapped addresses read zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_q <= 32'h0000_0000;
    end else if (bus_req && !wb_we_i) begin
      case (wb_adr_i)
        `PMCC_ADR_MODE: rd_q <= {24'h00_0000, power_mode_register_q};
        `PMCC_ADR_OPTION: rd_q <= {24'h00_0000, option_q};
        // Status: decoded mode, power state, legality, reset
        `PMCC_ADR_STATUS: rd_q <= {16'h0000, irst_cnt_q, 1'b0, mode, ps_q, legal, irst_q};
        default: rd_q <= 32'h0000_0000;
      endcase
    end
  end
  assign wb_dat_o = rd_q;
  assign wb_ack_o = ack_q;

  // Mode register; an illegal value is replaced by the reset value
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      power_mode_register_q <= `PMCC_MODE_RST;
    end else if (!legal) begin
      // Back to high speed with the 4k window
      power_mode_register_q <= `PMCC_MODE_RST;
    end else if (wr_mode && !irst_q) begin
      // Reserved bit 3 is not stored and reads zero
      power_mode_register_q <= wb_dat_i[7:0] & `PMCC_MODE_WMASK;
    end
  end

  // HALT availability option
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      option_q <= `PMCC_OPTION_RST;
    end else if (wr_option) begin
      option_q <= {7'h00, wb_dat_i[`PMCC_BIT_HALT_EN]};
    end
  end

  // Instruction cycle divider; keeps running through power save
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_q <= 3'h0;
    end else if (tc_tick) begin
      div_q <= 3'h0;
    end else begin
      div_q <= div_q + 3'h1;
    end
  end
  assign tc_tick = (div_q == 3'(`PMCC_TC_CYC - 1));
  assign tc_mid = (div_q == `PMCC_TC_MID);

  // Low nibble of the idle timer; it stops only in HALT
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      idle_timer_lo_q <= 4'h0;
    end else if (tc_tick && ps_q != PMCC_PS_HALT) begin
      idle_timer_lo_q <= idle_timer_lo_q - 4'h1;
    end
  end

  // Internal reset: preset 00Fx, count down on instruction cycles
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irst_cnt_q <= 8'h00;
      irst_q <= 1'b0;
    end else if (!legal) begin
      irst_cnt_q <= `PMCC_IRST_HI | {4'h0, idle_timer_lo_q};
      irst_q <= 1'b1;
    end else if (irst_q && tc_tick) begin
      irst_cnt_q <= irst_cnt_q - 8'h01;
      if (irst_cnt_q == 8'h00) begin
        irst_q <= 1'b0;
      end
    end
  end
  assign internal_reset = irst_q;

  // Power save sequencer shared by all three run modes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ps_q <= PMCC_PS_RUN;
    end else if (irst_q || !legal) begin
      ps_q <= PMCC_PS_RUN;
    end else begin
      case (ps_q)
        PMCC_PS_RUN: begin
          // HALT wins when both request bits are set and the option bit enables HALT
          if (wr_portg && wb_dat_i[`PMCC_BIT_HALT] && option_q[`PMCC_BIT_HALT_EN]) begin
            ps_q <= PMCC_PS_HALT_PEND;
          end else if (wr_portg && wb_dat_i[`PMCC_BIT_IDLE]) begin
            ps_q <= PMCC_PS_IDLE;
          end
        end
        PMCC_PS_HALT_PEND: begin
          // Stop at the next midpoint of an instruction cycle, in this one or the following
          if (tc_mid) begin
            ps_q <= PMCC_PS_HALT;
          end
        end
        PMCC_PS_HALT: begin
          if (wake_up) begin
            ps_q <= PMCC_PS_RUN;
          end
        end
        PMCC_PS_IDLE: begin
          if (wake_up) begin
            ps_q <= PMCC_PS_RUN;
          end
        end
        default: ps_q <= PMCC_PS_RUN;
      endcase
    end
  end

  // Oscillator enables straight from the register bits
  always_comb begin
    slow_osc_en = power_mode_register_q[`PMCC_BIT_SLOW_OSC];
    fast_osc_en = power_mode_register_q[`PMCC_BIT_FAST_OSC];
  end

  // Clock selects; the invalid pair forces low speed until reset lands
  always_comb begin
    timer_clock_slow_select = power_mode_register_q[`PMCC_BIT_TIMER_SEL] | force_low;
    core_clock_slow_select = power_mode_register_q[`PMCC_BIT_CORE_SEL];
  end

  // Window select to timer tap; codes above 4 saturate at 64k
  always_comb begin
    if (power_mode_register_q[2:0] > `PMCC_WIN_MAX_SEL) begin
      window_tap = `PMCC_WIN_BASE_TAP + {2'h0, `PMCC_WIN_MAX_SEL};
    end else begin
      window_tap = `PMCC_WIN_BASE_TAP + {2'h0, power_mode_register_q[2:0]};
    end
  end

  // Clock gating per power save state
  always_comb begin
    core_clk_run = (ps_q == PMCC_PS_RUN) || (ps_q == PMCC_PS_HALT_PEND);
    // HALT also freezes the fast oscillator pin; IDLE keeps it
    fast_osc_pin_run = (ps_q != PMCC_PS_HALT) & fast_osc_en;
    idle_timer_run = (ps_q != PMCC_PS_HALT);
    halt_active = (ps_q == PMCC_PS_HALT);
    idle_active = (ps_q == PMCC_PS_IDLE);
  end

  // Checks; one clock domain, all quiet while chip reset is low
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Accepted HALT request from the run state
  sequence s_halt_req;
    wr_portg && wb_dat_i[`PMCC_BIT_HALT] && option_q[`PMCC_BIT_HALT_EN] && ps_q == PMCC_PS_RUN
      && legal && !irst_q;
  endsequence

  // Within one instruction cycle plus the pending step
  sequence s_halt_reached;
    ##[1:6] halt_active && !core_clk_run && !fast_osc_pin_run;
  endsequence

  // Register restored and internal reset raised on the next edge
  sequence s_reset_raised;
    ##1 irst_q && power_mode_register_q == `PMCC_MODE_RST;
  endsequence

  chk_halt_entry_time: assert property (s_halt_req |-> s_halt_reached)
    else $error("HALT not reached within one instruction cycle");

  chk_halt_option_block: assert property (
    (ps_q == PMCC_PS_RUN && !option_q[`PMCC_BIT_HALT_EN]) |=> ps_q != PMCC_PS_HALT_PEND)
    else $error("HALT taken while disabled");

  chk_illegal_reset: assert property (!legal |-> s_reset_raised)
    else $error("Illegal mode did not raise internal reset");

  chk_reset_preset: assert property ($rose(irst_q) |-> irst_cnt_q[7:4] == 4'hf)
    else $error("Internal reset preset wrong");

  // Judged on the written byte itself, not on the checker's own decode
  chk_legal_after_write: assert property (
    (wr_mode && !irst_q && legal && !(wb_dat_i[7:4] inside {`PMCC_PAT_HIGH, `PMCC_PAT_HD,
      `PMCC_PAT_DUAL, `PMCC_PAT_DL, `PMCC_PAT_LOW})) |=> !legal ##1 irst_q)
    else $error("Illegal value not caught after write");

  chk_mode_reset_value: assert property (
    $fell(irst_q) |-> (mode == PMCC_MODE_HIGH && !core_clock_slow_select
      && !timer_clock_slow_select))
    else $error("Not in high speed after internal reset");

  chk_rsvd_bit_zero: assert property (power_mode_register_q[3] == 1'b0)
    else $error("Reserved bit stored");

  chk_force_low_speed: assert property (
    force_low |-> timer_clock_slow_select && core_clock_slow_select)
    else $error("Invalid pair not forced to low speed");

  chk_idle_keeps_osc: assert property (
    idle_active |-> (core_clk_run == 1'b0 && idle_timer_run && fast_osc_pin_run == fast_osc_en))
    else $error("IDLE stopped oscillator or timer");

  chk_idle_entry: assert property (
    (wr_portg && wb_dat_i[`PMCC_BIT_IDLE] && !wb_dat_i[`PMCC_BIT_HALT] && ps_q == PMCC_PS_RUN
      && legal && !irst_q) |=> idle_active)
    else $error("IDLE not entered");

  chk_halt_gating: assert property (
    halt_active |-> (!core_clk_run && !fast_osc_pin_run && !idle_timer_run))
    else $error("HALT left a clock running");

  // Any wake level leaves either power save state on the next cycle
  chk_wake_resume: assert property (
    ((halt_active || idle_active) && wake_up && !irst_q)
      |=> (core_clk_run && !halt_active && !idle_active))
    else $error("Wake did not resume run");

  chk_bus_ack_pulse: assert property ((wb_cyc_i && wb_stb_i && !ack_q) |=> ack_q ##1 !ack_q)
    else $error("Ack not a single pulse");

endmodule
`default_nettype wire

// ---- include/pmcc_params.svh ----
// Overview of operation
// - Three run modes, each with HALT and IDLE
// - Option bit enables or blocks HALT requests
// - Power save keeps state; IDLE keeps oscillator, timer
// - Mode register resets to 40 hex
// - Bit 7 switches slow oscillator on or off
// - Bit 6 switches fast oscillator on or off
// - Bit 5 selects idle timer clock source
// - Bit 4 selects core clock source
// - Timer fast with core slow forces low speed
// - Bits 2 to 0 hold window select
// - Only five upper-nibble patterns are legal
// - Illegal upper pattern raises internal reset
// - Internal reset lasts 240 to 256 cycles
// - High speed mode follows every reset
// - HALT stops internal clock and fast oscillator pin
// - Port G bit 7 enters HALT mid next cycle; here at the next midpoint, which can fall in the current cycle
// - Window select chooses 4k to 64k, resets 4k
// - Port G bit 6 enters IDLE
`ifndef PMCC_PARAMS_SVH
`define PMCC_PARAMS_SVH

// Register byte addresses
`define PMCC_ADR_MODE 8'h00
`define PMCC_ADR_PORTG 8'h04
`define PMCC_ADR_OPTION 8'h08
`define PMCC_ADR_STATUS 8'h0c

// Reset values
`define PMCC_MODE_RST 8'h40
`define PMCC_OPTION_RST 8'h01

// Mode register fields
`define PMCC_BIT_SLOW_OSC 7
`define PMCC_BIT_FAST_OSC 6
`define PMCC_BIT_TIMER_SEL 5
`define PMCC_BIT_CORE_SEL 4
`define PMCC_MODE_WMASK 8'hf7

// Port G control and option fields
`define PMCC_BIT_HALT 7
`define PMCC_BIT_IDLE 6
`define PMCC_BIT_HALT_EN 0

// Legal upper-nibble patterns
`define PMCC_PAT_HIGH 4'h4
`define PMCC_PAT_HD 4'hc
`define PMCC_PAT_DUAL 4'he
`define PMCC_PAT_DL 4'hf
`define PMCC_PAT_LOW 4'hb

// Instruction cycle timing
`define PMCC_CLK_NS 10
`define PMCC_TC_NS 50
`define PMCC_TC_CYC ((`PMCC_TC_NS + `PMCC_CLK_NS - 1) / `PMCC_CLK_NS)
`define PMCC_TC_MID 3'h2

// Internal reset preset, high nibble above the idle timer low nibble
`define PMCC_IRST_HI 8'hf0

// Window select decode
`define PMCC_WIN_BASE_TAP 5'h0c
`define PMCC_WIN_MAX_SEL 3'h4

`endif

// ---- include/pmcc_pkg.sv ----
package pmcc_pkg;

  // Decoded operating mode of the upper nibble
  typedef enum logic [2:0] {
    PMCC_MODE_HIGH = 3'b000,
    PMCC_MODE_HD = 3'b001,
    PMCC_MODE_DUAL = 3'b010,
    PMCC_MODE_DL = 3'b011,
    PMCC_MODE_LOW = 3'b100,
    PMCC_MODE_BAD = 3'b111
  } pmcc_mode_t;

  // Power save state
  typedef enum logic [1:0] {
    PMCC_PS_RUN = 2'b00,
    PMCC_PS_HALT_PEND = 2'b01,
    PMCC_PS_HALT = 2'b10,
    PMCC_PS_IDLE = 2'b11
  } pmcc_ps_t;

endpackage

// ---- logic/pmcc_legal_check.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "pmcc_params.svh"

module pmcc_legal_check
  import pmcc_pkg::*;
(
  input wire logic [3:0] upper,
  output logic legal,
  output logic force_low,
  output pmcc_mode_t mode
);

  // Pattern decode of the four clock control bits
  always_comb begin
    legal = 1'b1;
    case (upper)
      `PMCC_PAT_HIGH: mode = PMCC_MODE_HIGH;
      `PMCC_PAT_HD: mode = PMCC_MODE_HD;
      `PMCC_PAT_DUAL: mode = PMCC_MODE_DUAL;
      `PMCC_PAT_DL: mode = PMCC_MODE_DL;
      `PMCC_PAT_LOW: mode = PMCC_MODE_LOW;
      default: begin
        // Anything else would strand the core
        mode = PMCC_MODE_BAD;
        legal = 1'b0;
      end
    endcase
  end

  // Timer fast with core slow is the invalid select pair
  assign force_low = ~upper[1] & upper[0];

endmodule
`default_nettype wire

// ---- test/pmcc_top_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "pmcc_params.svh"

module pmcc_top_bench;
  logic clk; // Core clock
  logic rst_b; // Chip reset, active low
  logic cyc, stb, we, wake, ack; // Bus strobes, ack and wake request
  logic [7:0] adr; // Byte address
  logic [3:0] sel; // Byte enables
  logic [31:0] wdat, rdat, rd; // Bus data
  logic slow, fast, tsel, csel, crun, prun, trun, irst, halt, idle;
  logic [4:0] tap; // Timer tap index
  int err_count, checks_done, n;
  logic [7:0] tbl [9] = '{8'hc0, 8'he3, 8'hf4, 8'hb5, 8'hf6, 8'he1, 8'hc2, 8'h40, 8'h4f};
  logic [7:0] v;
  logic [2:0] w;

  pmcc_top dut (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .wake_up(wake), .slow_osc_en(slow),
    .fast_osc_en(fast), .timer_clock_slow_select(tsel),
    .core_clock_slow_select(csel), .window_tap(tap), .core_clk_run(crun),
    .fast_osc_pin_run(prun), .idle_timer_run(trun), .internal_reset(irst),
    .halt_active(halt), .idle_active(idle));

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // One compare; unknowns never match
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Classic single cycle; holds request until ack is sampled high
  task automatic wb(input logic w_e, input logic [7:0] a, input logic [7:0] d,
                    input logic [3:0] s);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w_e;
    adr <= a;
    sel <= s;
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (k >= 20) chk(32'h0, 32'h1, "ack timeout");
  endtask

  // Verdict and end of run
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Timer select fast with core slow must never be seen on the pins
  always @(posedge clk) begin
    if (rst_b === 1'b1 && csel === 1'b1 && tsel !== 1'b1) chk(0, 1, "bad pair");
  end

  // Watchdog well beyond the longest expected run
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("CHECK FAILED at %0t: watchdog", $time);
    final_report();
  end

  initial begin
    {cyc, stb, we, wake} = 4'h0;
    adr = 8'h00;
    sel = 4'hf;
    wdat = 32'h0;
    err_count = 0;
    checks_done = 0;
    rst_b = 1'b0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    // Reset state
    wb(0, `PMCC_ADR_MODE, 8'h00, 4'hf);
    chk(rd, 32'h40, "mode reset");
    chk({fast, slow, tsel, csel, tap}, {4'b1000, 5'h0c}, "reset pins");
    wb(0, `PMCC_ADR_OPTION, 8'h00, 4'hf);
    chk(rd, 32'h01, "option reset");
    $display("test reset done");
    // Walk through every legal pattern and window code
    // Low speed is left through dual clock; dual to high takes two writes
    for (int i = 0; i < 9; i++) begin
      v = tbl[i];
      repeat (4) @(posedge clk);
      wb(1, `PMCC_ADR_MODE, v, 4'hf);
      wb(0, `PMCC_ADR_MODE, 8'h00, 4'hf);
      chk(rd, {24'h0, v & 8'hf7}, "mode readback");
      w = (v[2:0] > 3'h4) ? 3'h4 : v[2:0];
      chk({slow, fast, tsel, csel}, v[7:4], "osc and selects");
      chk(tap, 5'h0c + {2'b00, w}, "window tap");
      chk(irst, 1'b0, "legal no reset");
    end
    // Byte lane zero off: write dropped
    wb(1, `PMCC_ADR_MODE, 8'hc0, 4'he);
    wb(0, `PMCC_ADR_MODE, 8'h00, 4'hf);
    chk(rd, 32'h47, "sel gated write");
    // Unmapped address acked, reads zero
    wb(1, 8'h10, 8'h5a, 4'hf);
    wb(0, 8'h10, 8'h00, 4'hf);
    chk(rd, 32'h0, "unmapped read");
    $display("test modes done");
    // Illegal pattern: reset within a cycle, preset near 0xf0
    wb(1, `PMCC_ADR_MODE, 8'h50, 4'hf);
    @(posedge clk);
    chk(irst, 1'b1, "internal reset");
    wb(0, `PMCC_ADR_STATUS, 8'h00, 4'hf);
    chk(rd[0], 1'b1, "status reset bit");
    chk(rd[15:8] >= 8'hee, 1'b1, "preset");
    wb(0, `PMCC_ADR_MODE, 8'h00, 4'hf);
    chk(rd, 32'h40, "mode back to high");
    // Mode writes are ignored while reset runs
    wb(1, `PMCC_ADR_MODE, 8'hc0, 4'hf);
    wb(0, `PMCC_ADR_MODE, 8'h00, 4'hf);
    chk(rd, 32'h40, "write in reset");
    n = 13; // Edges since the internal reset was raised
    while (irst === 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    // 240 to 256 instruction cycles of five clocks, seen one edge late
    chk(n >= 1201 && n <= 1281, 1'b1, "reset length");
    $display("test illegal done");
    // HALT stops core clock, pin and idle timer
    wb(1, `PMCC_ADR_PORTG, 8'h80, 4'hf);
    n = 0;
    while (halt !== 1'b1 && n < 8) begin
      @(posedge clk);
      n++;
    end
    chk({halt, crun, prun, trun}, 4'b1000, "halt pins");
    chk(n < 8, 1'b1, "halt entry");
    @(posedge clk) wake <= 1'b1;
    @(posedge clk) wake <= 1'b0;
    repeat (2) @(posedge clk);
    chk({halt, crun}, 2'b01, "woken");
    // HALT disabled by option bit
    wb(1, `PMCC_ADR_OPTION, 8'h00, 4'hf);
    wb(1, `PMCC_ADR_PORTG, 8'h80, 4'hf);
    repeat (8) @(posedge clk);
    chk({halt, crun}, 2'b01, "halt blocked");
    // IDLE keeps oscillator, timer and register
    wb(1, `PMCC_ADR_PORTG, 8'h40, 4'hf);
    @(posedge clk);
    chk({idle, crun, prun, trun}, 4'b1011, "idle pins");
    wb(0, `PMCC_ADR_STATUS, 8'h00, 4'hf);
    chk(rd[3:2], 2'h3, "idle status");
    wb(0, `PMCC_ADR_MODE, 8'h00, 4'hf);
    chk(rd, 32'h40, "mode kept");
    $display("test power save done");
    final_report();
  end
endmodule
`default_nettype wire
